/* fsl_apb_regs.sv */
/*
 apb slave holding the controller's command, address, data and config registers.
 assumes apb with 32-bit data; answers with no wait state.
*/
`timescale 1ns/10ps
module fsl_apb_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic go,
	output logic [3:0] op_r,
	output logic [fsl_pkg::ADDR_W-1:0] addr_r,
	output logic [7:0] data_r,
	output fsl_pkg::fsl_cfg_t cfg_r,
	input wire logic [31:0] status
);
	logic acc;
	logic hit;

	assign acc = en && psel && penable;
	assign pready = 1'b1;
	assign hit = (paddr == fsl_pkg::REG_CMD) || (paddr == fsl_pkg::REG_ADDR) || (paddr == fsl_pkg::REG_DATA)
		|| (paddr == fsl_pkg::REG_CFG) || (paddr == fsl_pkg::REG_STATUS);
	assign pslverr = psel && penable && !hit;
	assign go = acc && pwrite && (paddr == fsl_pkg::REG_CMD);

	// ------------------------------------------------------------
	// writes
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r <= 4'h0;
			addr_r <= '0;
			data_r <= 8'h00;
			cfg_r <= '0;
		end else if (acc && pwrite) begin
			case (paddr)
				fsl_pkg::REG_CMD: op_r <= pwdata[3:0];
				fsl_pkg::REG_ADDR: addr_r <= pwdata[fsl_pkg::ADDR_W-1:0];
				fsl_pkg::REG_DATA: data_r <= pwdata[7:0];
				fsl_pkg::REG_CFG: cfg_r <= {pwdata[fsl_pkg::CFG_OVERRIDE], pwdata[fsl_pkg::CFG_POWERDOWN]};
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// reads
	// ------------------------------------------------------------
	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			fsl_pkg::REG_CMD: prdata = {28'h000_0000, op_r};
			fsl_pkg::REG_ADDR: prdata = 32'(addr_r);
			fsl_pkg::REG_DATA: prdata = {24'h00_0000, data_r};
			fsl_pkg::REG_CFG: prdata = {30'h0000_0000, cfg_r.powerdown, cfg_r.override_hv};
			fsl_pkg::REG_STATUS: prdata = status;
			default: prdata = 32'h0000_0000;
		endcase
	end
endmodule

/* fsl_ctrl.sv */
/*
 host-side controller that drives a byte-wide flash through its pins to set block
 and master lock-bits, clear block lock-bits, suspend and resume programming.
 assumes software orders operations over apb and polls the status register.
*/
// Implementation choices: the APB register port and the register offsets.
// How it works
// - while suspended only read array (except at the address of the suspended program), read status, resume are issued; others refused.
// - set lock-bit is setup write then block or master confirm write.
// - aborted clear leaves lock-bits undefined; host must repeat the clear.
// - host checks error bits after lock operations and clears status on error.
// - error bits stay until clear status command 50h is written.
`timescale 1ns/10ps
module fsl_ctrl #(
	parameter logic [7:0] CMD_CLEAR_CONFIRM = 8'hd0,
	parameter logic [7:0] CMD_SUSPEND = 8'hb0,
	parameter logic [7:0] CMD_RESUME = 8'hd0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [fsl_pkg::ADDR_W-1:0] flash_addr,
	output logic [7:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [7:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	input wire logic done_indicator_pin,
	output logic reset_powerdown_n,
	output logic high_override_req
);
	typedef enum logic [2:0] {S_IDLE, S_W1, S_W2, S_POLL, S_RD, S_CLR, S_FIN} fsl_seq_t;

	fsl_seq_t st_r;
	logic go;
	logic [3:0] op_reg;
	logic [fsl_pkg::ADDR_W-1:0] addr_reg;
	logic [7:0] data_reg;
	fsl_pkg::fsl_cfg_t cfg;
	logic [31:0] status;
	logic cyc_start;
	logic cyc_done;
	logic [7:0] cyc_rdata;
	fsl_pkg::fsl_req_t cyc_req;
	logic [3:0] op_r;
	logic [7:0] sr_r;
	logic [7:0] rd_byte_r;
	logic suspended_r;
	logic refused_r;
	logic locks_undef_r;
	logic error_r;
	logic override_r;
	logic allowed;
	logic is_lock_op;
	logic go_q;
	logic [fsl_pkg::ADDR_W-1:0] prog_addr_r;

	// ------------------------------------------------------------
	// register slave and pin cycle engine
	// ------------------------------------------------------------
	fsl_apb_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.en(clk_en),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.go(go),
		.op_r(op_reg),
		.addr_r(addr_reg),
		.data_r(data_reg),
		.cfg_r(cfg),
		.status(status)
	);

	fsl_flash_cycle u_cyc (
		.pclk(pclk),
		.presetn(presetn),
		.en(clk_en),
		.start(cyc_start),
		.req(cyc_req),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe),
		.flash_dq_in(flash_dq_in),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n)
	);

	assign status = {8'h00, rd_byte_r, sr_r, 2'b00, done_indicator_pin, error_r, locks_undef_r, refused_r,
		suspended_r, (st_r != S_IDLE)};
	assign is_lock_op = (op_r == fsl_pkg::OP_SET_BLOCK) || (op_r == fsl_pkg::OP_SET_MASTER)
		|| (op_r == fsl_pkg::OP_CLEAR_LOCKS);

	// ------------------------------------------------------------
	// admission of new operations
	// ------------------------------------------------------------
	always_comb begin
		allowed = 1'b1;
		if (suspended_r)
			allowed = (op_reg == fsl_pkg::OP_READ_ARRAY) || (op_reg == fsl_pkg::OP_READ_STATUS)
				|| (op_reg == fsl_pkg::OP_RESUME);
		else if (op_reg == fsl_pkg::OP_RESUME)
			allowed = 1'b0;
		if (op_reg == 4'h0 || op_reg > 4'(fsl_pkg::OP_PROGRAM))
			allowed = 1'b0;
		if (suspended_r && op_reg == fsl_pkg::OP_READ_ARRAY && addr_reg == prog_addr_r)
			allowed = 1'b0;
	end

	// ------------------------------------------------------------
	// write and read requests per step
	// ------------------------------------------------------------
	always_comb begin
		cyc_req = '{wr: 1'b1, addr: addr_reg, data: fsl_pkg::CMD_READ_STATUS};
		cyc_start = 1'b0;
		case (st_r)
			S_W1: begin
				cyc_start = 1'b1;
				case (op_r)
					fsl_pkg::OP_SET_BLOCK, fsl_pkg::OP_SET_MASTER, fsl_pkg::OP_CLEAR_LOCKS:
						cyc_req.data = fsl_pkg::CMD_LOCK_SETUP;
					fsl_pkg::OP_SUSPEND: cyc_req.data = CMD_SUSPEND;
					fsl_pkg::OP_RESUME: cyc_req.data = CMD_RESUME;
					fsl_pkg::OP_CLEAR_STATUS: cyc_req.data = fsl_pkg::CMD_CLEAR_STATUS;
					fsl_pkg::OP_READ_ARRAY: cyc_req.data = fsl_pkg::CMD_READ_ARRAY;
					fsl_pkg::OP_PROGRAM: cyc_req.data = fsl_pkg::CMD_PROGRAM;
					default: cyc_req.data = fsl_pkg::CMD_READ_STATUS;
				endcase
			end
			S_W2: begin
				cyc_start = 1'b1;
				case (op_r)
					fsl_pkg::OP_SET_BLOCK: cyc_req.data = fsl_pkg::CMD_BLOCK_CONFIRM;
					fsl_pkg::OP_SET_MASTER: cyc_req.data = fsl_pkg::CMD_MASTER_CONFIRM;
					fsl_pkg::OP_CLEAR_LOCKS: cyc_req.data = CMD_CLEAR_CONFIRM;
					default: cyc_req.data = data_reg;
				endcase
			end
			S_POLL, S_RD: begin
				cyc_start = 1'b1;
				cyc_req.wr = 1'b0;
			end
			S_CLR: begin
				cyc_start = 1'b1;
				cyc_req.data = fsl_pkg::CMD_CLEAR_STATUS;
			end
			default: cyc_start = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// operation sequencer
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= S_IDLE;
			op_r <= 4'h0;
		end else if (clk_en) begin
			case (st_r)
				S_IDLE: begin
					if (go_q && allowed) begin
						st_r <= S_W1;
						op_r <= op_reg;
					end
				end
				S_W1: begin
					if (cyc_done) begin
						case (op_r)
							fsl_pkg::OP_SET_BLOCK, fsl_pkg::OP_SET_MASTER, fsl_pkg::OP_CLEAR_LOCKS,
							fsl_pkg::OP_PROGRAM: st_r <= S_W2;
							fsl_pkg::OP_SUSPEND: st_r <= S_POLL;
							fsl_pkg::OP_READ_STATUS, fsl_pkg::OP_READ_ARRAY: st_r <= S_RD;
							default: st_r <= S_FIN;
						endcase
					end
				end
				S_W2: begin
					if (cyc_done)
						st_r <= (op_r == fsl_pkg::OP_PROGRAM) ? S_FIN : S_POLL;
				end
				S_POLL: begin
					if (cyc_done && cyc_rdata[fsl_pkg::SR_READY]) begin
						if (is_lock_op && ((cyc_rdata & fsl_pkg::SR_ERR_MASK) != 8'h00))
							st_r <= S_CLR;
						else
							st_r <= S_FIN;
					end
				end
				S_RD: if (cyc_done) st_r <= S_FIN;
				S_CLR: if (cyc_done) st_r <= S_FIN;
				S_FIN: st_r <= S_IDLE;
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// reported state
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_r <= 8'h00;
			rd_byte_r <= 8'h00;
		end else if (clk_en && cyc_done && (st_r == S_POLL || st_r == S_RD)) begin
			if (st_r == S_RD)
				rd_byte_r <= cyc_rdata;
			if (st_r == S_POLL || op_r == fsl_pkg::OP_READ_STATUS)
				sr_r <= cyc_rdata;
		end
	end

	// error flag follows status bytes only, never array data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			error_r <= 1'b0;
		else if (clk_en && cyc_done && cyc_rdata[fsl_pkg::SR_READY]
			&& (st_r == S_POLL || (st_r == S_RD && op_r == fsl_pkg::OP_READ_STATUS)))
			error_r <= (cyc_rdata & fsl_pkg::SR_ERR_MASK) != 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			suspended_r <= 1'b0;
		else if (clk_en) begin
			if (st_r == S_POLL && cyc_done && op_r == fsl_pkg::OP_SUSPEND && cyc_rdata[fsl_pkg::SR_READY])
				suspended_r <= cyc_rdata[fsl_pkg::SR_PROG_SUSPENDED];
			else if (st_r == S_W1 && cyc_done && op_r == fsl_pkg::OP_RESUME)
				suspended_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			refused_r <= 1'b0;
		else if (clk_en && go_q)
			refused_r <= (st_r != S_IDLE) || !allowed;
	end

	// command word lands on the go edge, so it is judged one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			go_q <= 1'b0;
		else if (clk_en)
			go_q <= go;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prog_addr_r <= '0;
		else if (clk_en && st_r == S_W2 && cyc_done && op_r == fsl_pkg::OP_PROGRAM)
			prog_addr_r <= addr_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			locks_undef_r <= 1'b0;
		else if (clk_en && op_r == fsl_pkg::OP_CLEAR_LOCKS) begin
			if ((st_r == S_W2 || st_r == S_POLL) && cfg.powerdown)
				locks_undef_r <= 1'b1;
			else if (st_r == S_POLL && cyc_done && cyc_rdata[fsl_pkg::SR_READY])
				locks_undef_r <= cyc_rdata[fsl_pkg::SR_SUPPLY_LOW];
		end
	end

	// ------------------------------------------------------------
	// reset and override pin control
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			override_r <= 1'b0;
		else if (clk_en && st_r == S_IDLE)
			override_r <= cfg.override_hv;
	end

	assign high_override_req = override_r && reset_powerdown_n;
	assign reset_powerdown_n = ~cfg.powerdown;
endmodule

/* fsl_ctrl_properties.sv */
/*
 checker for the flash lock controller: flash pin timing and apb answers.
 assumes it is bound to fsl_ctrl, one clock pclk, clk_en held high.
*/
`timescale 1ns/10ps
module fsl_ctrl_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [fsl_pkg::ADDR_W-1:0] flash_addr,
	input wire logic [7:0] flash_dq_out,
	input wire logic flash_dq_oe,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic reset_powerdown_n,
	input wire logic high_override_req
);
	// --------------------------------
	// pin and bus checks
	// --------------------------------
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n)
		else $error("write strobe low without chip select");
	chk_no_we_oe: assert property (!(!flash_we_n && !flash_oe_n))
		else $error("write and read strobes low together");
	chk_dq_on_write: assert property (!flash_we_n |-> flash_dq_oe)
		else $error("data not driven during write strobe");
	chk_dq_off_read: assert property (!flash_oe_n |-> !flash_dq_oe)
		else $error("data driven during read strobe");
	chk_we_pulse_width: assert property ($fell(flash_we_n) |=> !flash_we_n [*4] ##1 flash_we_n)
		else $error("write strobe width wrong");
	chk_oe_pulse_width: assert property ($fell(flash_oe_n) |=> !flash_oe_n [*8] ##1 !flash_oe_n ##1 flash_oe_n)
		else $error("read strobe width wrong");
	chk_addr_held_write: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out))
		else $error("address or data moved during write strobe");
	chk_override_rp_high: assert property (high_override_req |-> reset_powerdown_n)
		else $error("override requested while reset pin low");
	chk_override_held: assert property (!flash_we_n |-> $stable(high_override_req))
		else $error("override changed during write strobe");
	chk_apb_zero_wait: assert property (psel && penable |-> pready)
		else $error("apb access not answered at once");
	chk_unmapped_error: assert property (psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10})
		|-> pslverr && prdata == 32'h0)
		else $error("unmapped access not flagged");
	cover property ($fell(flash_we_n));
	cover property ($fell(flash_oe_n));
	cover property (high_override_req && !flash_we_n);
endmodule
bind fsl_ctrl fsl_ctrl_properties u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
	.flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .reset_powerdown_n,
	.high_override_req);

/* fsl_ctrl_tb.sv */
/*
 self-checking bench for fsl_ctrl: apb orders, flash model, status checks.
 assumes the flash model of this folder and the checker bound to the dut.
*/
`timescale 1ns/10ps
module fsl_ctrl_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic vpp_low = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, done_indicator_pin;
	logic reset_powerdown_n, high_override_req;
	logic [fsl_pkg::ADDR_W-1:0] flash_addr;
	logic [7:0] flash_dq_out, flash_dq_in;
	logic [4:0] blk;
	logic [3:0] rc[3] = '{4'h0, 4'h5, 4'ha};
	logic [31:0] exp_q[$], msk_q[$];
	int err_count = 0;
	int checks = 0;
	int n;
	localparam logic [31:0] M = 32'h0000ff1f;
	fsl_ctrl dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_oe_n, .flash_we_n,
		.done_indicator_pin, .reset_powerdown_n, .high_override_req);
	fsl_flash_model u_flash (.pclk, .presetn, .flash_addr, .flash_dq_out, .flash_ce_n, .flash_oe_n, .flash_we_n,
		.reset_powerdown_n, .high_override_req, .vpp_low, .flash_dq_in, .done_indicator_pin);
	// --------------------------------
	// clock, bus tasks, result watcher
	// --------------------------------
	initial begin
		forever #5 pclk = ~pclk;
	end
	function automatic logic [31:0] es(input logic [7:0] sr, input logic [4:0] lo);
		es = {16'h0, sr, 3'h0, lo};
	endfunction
	task automatic summarize();
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic bound(input int k, input int lim);
		if (k >= lim) begin
			err_count++;
			summarize();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, m);
		int k;
		k = 0;
		if (!w) begin
			exp_q.push_back(e);
			msk_q.push_back(m);
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		bound(k, 50);
		rv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic op(input logic [3:0] c, input logic [31:0] e, m);
		int k;
		k = 0;
		apb(1'b1, 8'h00, {28'h0, c}, 32'h0, 32'h0);
		do begin
			apb(1'b0, 8'h10, 32'h0, 32'h0, 32'h0);
			k++;
		end while (rv[0] !== 1'b0 && k < 400);
		bound(k, 400);
		apb(1'b0, 8'h10, 32'h0, e, m);
	endtask
	task automatic cfg(input logic hv);
		apb(1'b1, 8'h0c, {31'h0, hv}, 32'h0, 32'h0);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			checks++;
			if ((prdata & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
				$display("BAD prdata at %h expected %h seen %h", paddr, exp_q[0] & msk_q[0], prdata & msk_q[0]);
				err_count++;
			end
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		rv = $urandom(70);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h10, 32'h0, 32'h20, 32'h3f);
		apb(1'b0, 8'h0c, 32'h0, 32'h0, '1);
		apb(1'b0, 8'h14, 32'h0, 32'h0, '1);
		blk = 5'($urandom % 32);
		apb(1'b1, 8'h04, {11'h0, blk, 16'h0005}, 32'h0, 32'h0);
		op(4'h1, es(8'h80, 5'h00), M);
		apb(1'b1, 8'h08, $urandom, 32'h0, 32'h0);
		op(4'h9, 32'h0, 32'h0);
		op(4'h7, es(8'h92, 5'h10), M);
		op(4'h6, 32'h0, 32'h0);
		op(4'h7, es(8'h80, 5'h00), M);
		op(4'h2, es(8'h92, 5'h10), M);
		op(4'h7, es(8'h80, 5'h00), M);
		cfg(1'b1);
		op(4'h2, es(8'h80, 5'h00), M);
		cfg(1'b0);
		apb(1'b1, 8'h04, {11'h0, blk ^ 5'h01, 16'h0005}, 32'h0, 32'h0);
		op(4'h1, es(8'h92, 5'h10), M);
		cfg(1'b1);
		op(4'h1, es(8'h80, 5'h00), M);
		cfg(1'b0);
		op(4'h3, es(8'ha2, 5'h10), M);
		vpp_low <= 1'b1;
		cfg(1'b1);
		op(4'h3, es(8'ha8, 5'h18), M);
		vpp_low <= 1'b0;
		op(4'h3, es(8'h80, 5'h00), M);
		cfg(1'b0);
		apb(1'b1, 8'h04, {11'h0, blk, 16'h0005}, 32'h0, 32'h0);
		op(4'h9, 32'h0, 32'h0);
		op(4'h4, es(8'h84, 5'h02), M);
		op(4'h1, es(8'h84, 5'h06), M);
		op(4'h8, 32'h4, 32'h4);
		apb(1'b1, 8'h04, {11'h0, blk ^ 5'h02, 16'h0005}, 32'h0, 32'h0);
		op(4'h8, 32'h00fa0002, 32'h00ff0016);
		op(4'h5, 32'h0, 32'h7);
		op(4'h7, 32'h0, 32'h8006);
		n = 0;
		do begin
			op(4'h7, 32'h0, 32'h0);
			n++;
		end while (rv[15] !== 1'b1 && n < 40);
		bound(n, 40);
		op(4'h7, es(8'h80, 5'h00), M);
		foreach (rc[i])
			op(rc[i], 32'h4, 32'h4);
		summarize();
	end
endmodule

/* fsl_flash_cycle.sv */
/*
 runs one flash bus cycle, a write pulse or a timed read, on the chip pins.
 assumes the flash needs no clock and latches address and data on the write strobe.
*/
`timescale 1ns/10ps
module fsl_flash_cycle #(
	parameter int WR_CYC = fsl_pkg::WR_PULSE_CYC,
	parameter int RD_CYC = fsl_pkg::RD_ACCESS_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic start,
	input wire fsl_pkg::fsl_req_t req,
	output logic done,
	output logic [7:0] rdata,
	output logic [fsl_pkg::ADDR_W-1:0] flash_addr,
	output logic [7:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [7:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n
);
	typedef enum logic [1:0] {C_IDLE, C_SETUP, C_ACT, C_HOLD} fsl_cyc_t;
	fsl_cyc_t st_r;
	logic [7:0] cnt_r;
	logic wr_r;

	assign done = en && (st_r == C_HOLD);

	// ------------------------------------------------------------
	// cycle sequencing
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= C_IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
		end else if (en) begin
			case (st_r)
				C_IDLE: begin
					if (start) begin
						st_r <= C_SETUP;
						wr_r <= req.wr;
					end
				end
				C_SETUP: begin
					st_r <= C_ACT;
					cnt_r <= wr_r ? 8'(WR_CYC - 1) : 8'(RD_CYC - 1);
				end
				C_ACT: begin
					if (cnt_r == 8'h00)
						st_r <= C_HOLD;
					else
						cnt_r <= cnt_r - 8'h01;
				end
				C_HOLD: st_r <= C_IDLE;
				default: st_r <= C_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_addr <= '0;
			flash_dq_out <= 8'h00;
			flash_dq_oe <= 1'b0;
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
			rdata <= 8'h00;
		end else if (en) begin
			case (st_r)
				C_IDLE: begin
					flash_ce_n <= 1'b1;
					flash_dq_oe <= 1'b0;
					if (start) begin
						flash_addr <= req.addr;
						flash_dq_out <= req.data;
						flash_dq_oe <= req.wr;
						flash_ce_n <= 1'b0;
					end
				end
				C_SETUP: begin
					flash_we_n <= ~wr_r;
					flash_oe_n <= wr_r;
				end
				C_ACT: begin
					if (cnt_r == 8'h00) begin
						flash_we_n <= 1'b1;
						flash_oe_n <= 1'b1;
						if (!wr_r)
							rdata <= flash_dq_in;
					end
				end
				default: begin
					flash_we_n <= 1'b1;
					flash_oe_n <= 1'b1;
				end
			endcase
		end
	end
endmodule

/* fsl_flash_model.sv */
/*
 behavioural flash device: command decode, lock-bits, program and suspend.
 assumes the controller pins drive it; the bench clock times its operations.
*/
`timescale 1ns/10ps
module fsl_flash_model #(
	parameter int LOCK_CYC = 20,
	parameter int PROG_CYC = 300,
	parameter int SUSP_CYC = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [fsl_pkg::ADDR_W-1:0] flash_addr,
	input wire logic [7:0] flash_dq_out,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic reset_powerdown_n,
	input wire logic high_override_req,
	input wire logic vpp_low,
	output logic [7:0] flash_dq_in,
	output logic done_indicator_pin
);
	// --------------------------------
	// device state
	// --------------------------------
	logic [31:0] locks;
	logic master, busy, susp, we_q, w;
	logic [6:0] sr;
	logic [1:0] mode;
	logic [2:0] kind;
	logic [9:0] cnt, left;
	logic [7:0] d, last;
	logic [4:0] lb;
	assign d = flash_dq_out;
	assign w = flash_we_n && !we_q && !flash_ce_n;
	assign done_indicator_pin = !busy;
	// ready bit leads; lower bits only meaningful when ready
	assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? (mode == 2'd0 ? ~flash_addr[7:0] : {!busy, sr}) : ~last;
	always_ff @(posedge pclk) begin
		we_q <= flash_we_n;
		last <= flash_dq_in;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			locks <= '0;
			master <= 1'b0;
			busy <= 1'b0;
			susp <= 1'b0;
			sr <= 7'h00;
			mode <= 2'd0;
			kind <= 3'd0;
			cnt <= 10'd0;
			left <= 10'd0;
			lb <= 5'd0;
		end else if (!reset_powerdown_n) begin
			if (busy && kind == 3'd3)
				locks <= '1;
			busy <= 1'b0;
			susp <= 1'b0;
			sr <= 7'h00;
			mode <= 2'd0;
		end else if (w) begin
			mode <= 2'd1;
			if (mode == 2'd2) begin
				// override level taken at the confirm write
				if (d == 8'h01 && master && !high_override_req)
					sr <= sr | 7'h12;
				else if (d == 8'hf1 && !high_override_req)
					sr <= sr | 7'h12;
				else if (d == 8'hd0 && vpp_low)
					sr <= sr | 7'h28;
				else if (d == 8'hd0 && master && !high_override_req)
					sr <= sr | 7'h22;
				else if (d inside {8'h01, 8'hf1, 8'hd0}) begin
					busy <= 1'b1;
					cnt <= 10'(LOCK_CYC);
					lb <= flash_addr[20:16];
					kind <= d == 8'h01 ? 3'd1 : (d == 8'hf1 ? 3'd2 : 3'd3);
				end else
					sr <= sr | 7'h30;
			end else if (mode == 2'd3) begin
				if (locks[flash_addr[20:16]] && !high_override_req)
					sr <= sr | 7'h12;
				else begin
					busy <= 1'b1;
					cnt <= 10'(PROG_CYC);
					kind <= 3'd4;
				end
			end else if (susp && !(d inside {8'hff, 8'h70, 8'hd0}))
				mode <= mode;
			else if (d == 8'h60)
				mode <= 2'd2;
			else if (d == 8'h40)
				mode <= 2'd3;
			else if (d == 8'h50)
				sr <= sr & 7'h45;
			else if (d == 8'hff)
				mode <= 2'd0;
			else if (d == 8'hb0 && busy && kind == 3'd4) begin
				kind <= 3'd5;
				left <= cnt;
				cnt <= 10'(SUSP_CYC);
			end else if (d == 8'hd0 && susp) begin
				susp <= 1'b0;
				sr[2] <= 1'b0;
				busy <= 1'b1;
				kind <= 3'd4;
				cnt <= left;
			end
		end else if (busy && cnt != 10'd0)
			cnt <= cnt - 10'd1;
		else if (busy) begin
			busy <= 1'b0;
			case (kind)
				3'd1: locks[lb] <= 1'b1;
				3'd2: master <= 1'b1;
				3'd3: locks <= '0;
				3'd5: begin
					susp <= 1'b1;
					sr[2] <= 1'b1;
				end
				default: ;
			endcase
		end
	end
endmodule

/* fsl_pkg.sv */
/*
 holds the shared constants and types of the flash suspend and lock controller:
 command codes, status bit positions, apb register map, operation codes, timing.
 assumes a byte-wide flash driven over its asynchronous write/read pins.
*/
package fsl_pkg;
	// ------------------------------------------------------------
	// flash side
	// ------------------------------------------------------------
	localparam int ADDR_W = 21;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h01;
	localparam logic [7:0] CMD_MASTER_CONFIRM = 8'hf1;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam int SR_READY = 7;
	localparam int SR_ERASE_CLEAR_ERR = 5;
	localparam int SR_PROGRAM_SET_ERR = 4;
	localparam int SR_SUPPLY_LOW = 3;
	localparam int SR_PROG_SUSPENDED = 2;
	localparam int SR_PROTECT = 1;
	localparam logic [7:0] SR_ERR_MASK = 8'h3a;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int T_WR_PULSE_NS = 50;
	localparam int T_RD_ACCESS_NS = 100;
	localparam int WR_PULSE_CYC = (T_WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_ACCESS_CYC = (T_RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	// ------------------------------------------------------------
	// apb register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_CFG = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int CFG_OVERRIDE = 0;
	localparam int CFG_POWERDOWN = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_SUSPENDED = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_LOCKS_UNDEF = 3;
	localparam int ST_ERROR = 4;
	localparam int ST_READY_PIN = 5;
	localparam int ST_SR_LSB = 8;
	localparam int ST_DATA_LSB = 16;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// ------------------------------------------------------------
	// operations and carriers
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_SET_BLOCK = 4'h1,
		OP_SET_MASTER = 4'h2,
		OP_CLEAR_LOCKS = 4'h3,
		OP_SUSPEND = 4'h4,
		OP_RESUME = 4'h5,
		OP_CLEAR_STATUS = 4'h6,
		OP_READ_STATUS = 4'h7,
		OP_READ_ARRAY = 4'h8,
		OP_PROGRAM = 4'h9
	} fsl_op_t;
	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} fsl_req_t;
	typedef struct packed {
		logic override_hv;
		logic powerdown;
	} fsl_cfg_t;
endpackage
